// *** rtl/cgc_clock_generator_control.sv ***
// Clock generator control: power-up delay, pin modes, write-once mode register, clock routing.
// How it works
// - With detector default start on, a fast supply rise inserts stabilization delay first.
// - External main clock input needs no oscillation stabilization wait before use.
// - Main oscillator output pin stays an input port until mode register selects any main code other than port; input pin until crystal.
// - Exactly one single 8-bit write to the mode register is accepted after reset.
// - Subsystem oscillator pins stay input ports until subsystem oscillator is selected.
// - CPU on subsystem clock feeds peripherals too, except counter, buzzer, watchdog.
`timescale 1ns/1ps
module cgc_clock_generator_control #(
  parameter int unsigned STAB_CYC = cgc_pkg::SUPPLY_STAB_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Supply monitor inputs, asynchronous.
  input wire logic lowvolt_default_off_opt_in,
  input wire logic supply_above_low_in,
  input wire logic supply_above_high_in,
  // Mode register write port, CPU clock source and main oscillator ready inputs.
  input wire logic mode_wr_in,
  input wire logic [7:0] mode_wdata_in,
  input wire logic cpu_on_subclk_in,
  input wire logic main_osc_ready_in,
  // Status outputs.
  output logic [7:0] clock_operation_mode_reg_out,
  output logic mode_locked_out,
  output logic reset_hold_out,
  output logic main_clk_usable_out,
  // Pin function selection: 1 means the pin is a general-purpose input port, except the external clock input enable.
  output logic main_osc_in_pin_port_out,
  output logic main_osc_out_ext_pin_port_out,
  output logic sub_osc_in_pin_port_out,
  output logic sub_osc_out_pin_port_out,
  output logic ext_main_clock_input_en_out,
  // Peripheral clock source select: 1 routes the subsystem clock.
  output logic periph_on_subclk_out,
  output logic fixed_src_periph_on_subclk_out
);
  // Index of each supply monitor input inside the synchroniser vector.
  localparam int unsigned SYNC_N = 3;
  localparam int unsigned SUP_LOW_BIT = 0;
  localparam int unsigned SUP_HIGH_BIT = 1;
  localparam int unsigned DET_ON_BIT = 2;

  logic [SYNC_N-1:0] async_in;
  logic [SYNC_N-1:0] sync1_r;
  logic [SYNC_N-1:0] sync2_r;
  logic supply_low_s;
  logic supply_high_s;
  logic detector_on_s;
  logic [7:0] mode_r;
  logic locked_r;
  logic [cgc_pkg::CNT_W-1:0] cnt_r;
  logic armed_r;
  logic hold_r;
  logic periph_sub_r;
  logic main_in_port_r;
  logic main_out_port_r;
  logic sub_port_r;
  logic ext_en_r;
  logic start_wait;
  logic wait_done;
  logic mode_take;
  logic [1:0] wr_sel;
  logic [1:0] main_sel;
  cgc_pkg::cgc_state_t state_r;

  // Main selection decoders, shared by the pin, clock-enable and usable logic.
  function automatic logic sel_is_port(input logic [1:0] sel);
    return sel == cgc_pkg::MAIN_PORT;
  endfunction

  function automatic logic sel_is_xtal(input logic [1:0] sel);
    return sel == cgc_pkg::MAIN_XTAL;
  endfunction

  function automatic logic sel_is_ext(input logic [1:0] sel);
    return sel == cgc_pkg::MAIN_EXT;
  endfunction

  // Asynchronous supply pins pass two flip-flops; only the second stage is ever read.
  assign async_in = {lowvolt_default_off_opt_in, supply_above_high_in, supply_above_low_in};
  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
      end else begin
        sync1_r[i] <= async_in[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  assign supply_low_s = sync2_r[SUP_LOW_BIT];
  assign supply_high_s = sync2_r[SUP_HIGH_BIT];
  assign detector_on_s = sync2_r[DET_ON_BIT];

  // The wait starts once the low threshold is seen with the detector default start on.
  assign start_wait = (state_r == cgc_pkg::CGC_IDLE) && supply_low_s && detector_on_s;
  assign wait_done = (state_r == cgc_pkg::CGC_WAIT) && (cnt_r <= cgc_pkg::CNT_ONE);

  // Supply sequencer state: idle, counting the stabilization time, then running.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= cgc_pkg::CGC_IDLE;
    end else begin
      unique case (state_r)
        cgc_pkg::CGC_IDLE: begin
          if (start_wait) begin
            state_r <= cgc_pkg::CGC_WAIT;
          end
        end
        cgc_pkg::CGC_WAIT: begin
          if (wait_done) begin
            state_r <= cgc_pkg::CGC_RUN;
          end
        end
        cgc_pkg::CGC_RUN: begin
          // A supply drop below the low threshold rearms the whole sequence.
          if (!supply_low_s) begin
            state_r <= cgc_pkg::CGC_IDLE;
          end
        end
        default: begin
          state_r <= cgc_pkg::CGC_IDLE;
        end
      endcase
    end
  end

  // Stabilization counter, loaded on entry to the wait and run down to zero.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= cgc_pkg::CNT_ZERO;
    end else if (start_wait) begin
      cnt_r <= cgc_pkg::CNT_W'(STAB_CYC);
    end else if (wait_done) begin
      cnt_r <= cgc_pkg::CNT_ZERO;
    end else if (state_r == cgc_pkg::CGC_WAIT) begin
      cnt_r <= cnt_r - cgc_pkg::CNT_ONE;
    end
  end

  // Remembers that the high threshold came while the count was still running.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed_r <= 1'b0;
    end else if (start_wait) begin
      armed_r <= 1'b0;
    end else if ((state_r == cgc_pkg::CGC_WAIT) && supply_high_s) begin
      armed_r <= 1'b1;
    end
  end

  // Reset processing is held off for the rest of the count once a fast rise is seen;
  // a slow rise that misses the window never raises the hold.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_r <= 1'b0;
    end else if ((state_r == cgc_pkg::CGC_WAIT) && !wait_done) begin
      hold_r <= supply_high_s || armed_r;
    end else begin
      hold_r <= 1'b0;
    end
  end

  assign mode_take = mode_wr_in && !locked_r;
  assign wr_sel = mode_wdata_in[cgc_pkg::MAIN_SEL_LO +: cgc_pkg::MAIN_SEL_W];

  // Write-once mode register; one byte write per reset, later writes have no effect.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_r <= cgc_pkg::MODE_RST;
      locked_r <= 1'b0;
    end else if (mode_take) begin
      mode_r <= mode_wdata_in;
      locked_r <= 1'b1;
    end
  end

  // Pin functions live in flip-flops loaded by the same accepted write, so they change
  // together with the register and never glitch while it is decoded.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      main_in_port_r <= 1'b1;
      main_out_port_r <= 1'b1;
      sub_port_r <= 1'b1;
      ext_en_r <= 1'b0;
    end else if (mode_take) begin
      main_in_port_r <= !sel_is_xtal(wr_sel);
      main_out_port_r <= sel_is_port(wr_sel);
      sub_port_r <= !mode_wdata_in[cgc_pkg::SUB_SEL_BIT];
      ext_en_r <= sel_is_ext(wr_sel);
    end
  end

  // Peripheral clock follows the CPU onto the subsystem clock; fixed-source units never do.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      periph_sub_r <= 1'b0;
    end else begin
      periph_sub_r <= cpu_on_subclk_in;
    end
  end

  assign main_sel = mode_r[cgc_pkg::MAIN_SEL_LO +: cgc_pkg::MAIN_SEL_W];
  assign clock_operation_mode_reg_out = mode_r;
  assign mode_locked_out = locked_r;
  assign reset_hold_out = hold_r;
  // The first main pin is released only by the crystal; an external clock enters on the second.
  assign main_osc_in_pin_port_out = main_in_port_r;
  assign main_osc_out_ext_pin_port_out = main_out_port_r;
  assign ext_main_clock_input_en_out = ext_en_r;
  assign sub_osc_in_pin_port_out = sub_port_r;
  assign sub_osc_out_pin_port_out = sub_port_r;
  // An external clock is usable at once; a crystal waits for its stabilization flag.
  assign main_clk_usable_out = sel_is_ext(main_sel) ||
                               (sel_is_xtal(main_sel) && main_osc_ready_in);
  assign periph_on_subclk_out = periph_sub_r;
  assign fixed_src_periph_on_subclk_out = 1'b0;
endmodule

// *** rtl/cgc_pkg.sv ***
// Package with constants for the clock generator control block.
package cgc_pkg;
  // Clock operation mode register field positions.
  localparam int unsigned MODE_W = 8;
  localparam int unsigned MAIN_SEL_LO = 6;
  localparam int unsigned MAIN_SEL_W = 2;
  localparam int unsigned SUB_SEL_BIT = 4;
  localparam logic [7:0] MODE_RST = 8'h00;
  // Main oscillator selection codes held in the top two mode bits.
  localparam logic [1:0] MAIN_PORT = 2'h0;
  localparam logic [1:0] MAIN_XTAL = 2'h1;
  localparam logic [1:0] MAIN_EXT = 2'h3;
  // Supply oscillation stabilization time in microseconds and its cycle count.
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SUPPLY_STAB_US = 100;
  localparam int unsigned SUPPLY_STAB_CYC = SUPPLY_STAB_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  // Power-up sequencer states.
  typedef enum logic [1:0] {
    CGC_IDLE = 2'h0,
    CGC_WAIT = 2'h1,
    CGC_RUN = 2'h3
  } cgc_state_t;
endpackage

// *** tb/cgc_clock_generator_control_tb.sv ***
// Self-checking bench for the clock generator control block.
`timescale 1ns/1ps
module cgc_clock_generator_control_tb;
  logic clk_in = 0, rstn_in = 0, opt = 0, lo = 0, hi = 0, rdy = 0, seen;
  logic wr, sub, lk, hold, us, ext, pr, fx, p0, p1, s0, s1;
  logic [7:0] wd, mode;
  int fail_count = 0, cmp_count = 0;
  initial forever #4 clk_in = ~clk_in;
  cgc_fw_model cgc_fw_model_i (.clk_in(clk_in), .wr_out(wr), .wdata_out(wd), .sub_out(sub));
  cgc_clock_generator_control #(.STAB_CYC(20)) cgc_clock_generator_control_i (.clk_in(clk_in),
    .rstn_in(rstn_in), .lowvolt_default_off_opt_in(opt), .supply_above_low_in(lo),
    .supply_above_high_in(hi), .mode_wr_in(wr), .mode_wdata_in(wd), .cpu_on_subclk_in(sub),
    .main_osc_ready_in(rdy), .clock_operation_mode_reg_out(mode), .mode_locked_out(lk),
    .reset_hold_out(hold), .main_clk_usable_out(us), .main_osc_in_pin_port_out(p0),
    .main_osc_out_ext_pin_port_out(p1), .sub_osc_in_pin_port_out(s0),
    .sub_osc_out_pin_port_out(s1), .ext_main_clock_input_en_out(ext),
    .periph_on_subclk_out(pr), .fixed_src_periph_on_subclk_out(fx));
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rst;
    rstn_in <= 0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1;
    @(posedge clk_in);
  endtask
  initial begin
    #16000 fail_count++;
    give_verdict;
  end
  initial begin
    rst;
    #1 chk({lk, us, p0, p1, s0, s1}, 8'h0F);
    @(posedge clk_in);
    opt <= 1;
    lo <= 1;
    repeat (5) @(posedge clk_in);
    hi <= 1;
    seen = 0;
    repeat (40) @(posedge clk_in) seen |= hold;
    chk({seen, hold}, 8'h02);
    cgc_fw_model_i.wr(8'hD0);
    #1 chk(mode, 8'hD0);
    chk({lk, p0, p1, s0, s1, us, ext}, 8'h63);
    cgc_fw_model_i.wr(8'h40);
    #1 chk(mode, 8'hD0);
    cgc_fw_model_i.run_sub(1);
    @(posedge clk_in);
    #1 chk({pr, fx}, 8'h02);
    rst;
    cgc_fw_model_i.wr(8'h40);
    #1 chk({mode[7:4], p0, p1, s0, s1}, 8'h43);
    chk({us, ext}, 8'h00);
    @(posedge clk_in);
    rdy <= 1;
    @(posedge clk_in);
    #1 chk({us, ext}, 8'h02);
    @(posedge clk_in);
    opt <= 0;
    rst;
    seen = 0;
    cgc_fw_model_i.wr(8'h90);
    repeat (30) @(posedge clk_in) seen |= hold;
    chk({seen, p0, p1, s0, s1, us, ext}, 8'h20);
    give_verdict;
  end
endmodule

// *** tb/cgc_fw_model.sv ***
// Firmware model that issues the mode write and moves the CPU clock source.
`timescale 1ns/1ps
module cgc_fw_model (
  input wire logic clk_in,
  output logic wr_out = 1'h0,
  output logic [7:0] wdata_out = 8'h00,
  output logic sub_out = 1'h0
);
  // One byte carries main and subsystem selects, since only one write lands.
  task wr(input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'h1;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'h0;
    wdata_out <= ~d;
  endtask
  // No oscillator stop, enable write or converter use is modelled.
  task run_sub(input logic v);
    @(posedge clk_in);
    sub_out <= v;
  endtask
endmodule

// *** tb/cgc_sva.sv ***
// Concurrent checks on the clock generator control ports.
`timescale 1ns/1ps
module cgc_sva #(parameter int unsigned STAB_CYC = 20) (
  input wire logic clk_in, rstn_in, mode_wr_in, cpu_on_subclk_in, mode_locked_out,
  input wire logic [7:0] mode_wdata_in, clock_operation_mode_reg_out,
  input wire logic reset_hold_out, main_clk_usable_out, periph_on_subclk_out,
  input wire logic main_osc_in_pin_port_out, main_osc_out_ext_pin_port_out,
  input wire logic sub_osc_in_pin_port_out, sub_osc_out_pin_port_out,
  input wire logic fixed_src_periph_on_subclk_out,
  input wire logic main_osc_ready_in, ext_main_clock_input_en_out
);
  localparam int HMAX = STAB_CYC + 2;
  wire logic [7:0] m = clock_operation_mode_reg_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_lock_on_write: assert property (mode_wr_in && !mode_locked_out |=>
    mode_locked_out && m == $past(mode_wdata_in)) else $error("mode write not taken");
  a_later_write_ignored: assert property (mode_locked_out |=> $stable(m))
    else $error("locked mode changed");
  a_main_pins_port: assert property (m[7:6] == 2'h0 |-> main_osc_in_pin_port_out
    && main_osc_out_ext_pin_port_out) else $error("main pin left port mode");
  a_sub_pins_port: assert property (!m[4] |-> sub_osc_in_pin_port_out
    && sub_osc_out_pin_port_out) else $error("sub pin left port mode");
  a_ext_no_wait: assert property (m[7:6] == 2'h3 |-> main_clk_usable_out)
    else $error("external clock waits");
  a_periph_follow: assert property (cpu_on_subclk_in |=> periph_on_subclk_out
    && !fixed_src_periph_on_subclk_out) else $error("peripheral clock wrong");
  a_hold_bounded: assert property ($rose(reset_hold_out) |-> ##[1:HMAX] !reset_hold_out)
    else $error("hold too long");
  a_xtal_waits_ready: assert property (m[7:6] == 2'h1 && !main_osc_ready_in |->
    !main_clk_usable_out) else $error("crystal used before ready");
  a_ext_input_select: assert property (ext_main_clock_input_en_out == (m[7:6] == 2'h3))
    else $error("external input enable wrong");
  a_periph_on_main: assert property (!cpu_on_subclk_in |=> !periph_on_subclk_out)
    else $error("peripheral clock left main");
endmodule
bind cgc_clock_generator_control cgc_sva #(.STAB_CYC(STAB_CYC)) cgc_sva_i (.*);
